// [hdl/ttbu_top.sv]
// Timer time-base unit: prescaler, counter, auto-reload and update logic
//
// The register addresses and the strobed register port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
// How it works
// (R1) A 16-bit auto-reload counter counting up, down or up/down.
// (R2) Programmable prescaler divides the counter clock by 1 to 65536.
// (R3) Prescaler value is buffered and takes effect at the next update.
// (R4) Reload shadow loads at once without preload, else only on update.
// (R5) Overflow, underflow or software request makes an update unless disabled.
// (R6) Counter clock runs only while enabled, starting one cycle after enable; the code also stops it one cycle after disable.
// (R7) Up mode: count 0 to reload value, wrap to 0, overflow.
// (R8) Request source set: software update does not raise the update flag.
// (R9) Allowed update sets flag, loads reload shadow if preloaded, loads prescaler.
// (R10) Update disable blocks every update, shadows stay unchanged.
// (R11) Software update clears counter and prescaler count, keeps division value.
// (R12) Prescaler, counter and reload registers are accessible at any time.
// (R13) Down mode: count from reload value to 0, restart, underflow.
// (R14) Centre mode: up to reload value, down to 0; hardware direction.
// (R15) Software update request bit clears itself after being acted on.
// (R16) Outside centre mode direction bit selects up (0) or down (1).
// (R17) Reset clears counter, prescaler, flag and control; counter disabled.
module ttbu_top (
  // Clock and reset
  input  wire logic                        clk_sys_in,
  input  wire logic                        rst_n_in,
  // Register port
  input  wire logic [ttbu_pkg::ADDR_W-1:0] addr_in,
  input  wire logic [ttbu_pkg::DATA_W-1:0] wdata_in,
  input  wire logic                        wr_in,
  input  wire logic                        rd_in,
  output logic      [ttbu_pkg::DATA_W-1:0] rdata_out,
  // Events
  output logic                             update_event_out,
  output logic                             irq_out
);
  import ttbu_pkg::*;

  // ---------------------------------------------------------------
  // Software-visible and internal state
  // ---------------------------------------------------------------
  logic             counter_enable;
  logic             update_disable;
  logic             update_request_source;
  logic             direction;
  logic [1:0]       center_align_select;
  logic             reload_preload_enable;
  logic             update_request;
  logic             update_flag;
  logic             update_mask;
  logic [CNT_W-1:0] counter_register;
  logic [CNT_W-1:0] prescaler_register;
  logic [CNT_W-1:0] reload_register;
  logic [CNT_W-1:0] reload_shadow;
  logic [CNT_W-1:0] prescaler_shadow;
  logic             counter_run;
  ttbu_dir_t        center_dir;

  logic             wr_ctrl;
  logic             wr_evt;
  logic             wr_sts;
  logic             wr_mask;
  logic             wr_cnt;
  logic             wr_psc;
  logic             wr_arr;
  logic             counter_clock;
  logic             center_mode;
  logic             count_down;
  logic             overflow;
  logic             underflow;
  logic             sw_update;
  logic             hw_update;
  logic             update_event;
  logic             flag_set;
  logic [CNT_W-1:0] next_count;

  assign wr_ctrl = wr_in && (addr_in == CTRL_OFFSET);
  assign wr_evt  = wr_in && (addr_in == EVTGEN_OFFSET);
  assign wr_sts  = wr_in && (addr_in == STATUS_OFFSET);
  assign wr_mask = wr_in && (addr_in == MASK_OFFSET);
  assign wr_cnt  = wr_in && (addr_in == COUNT_OFFSET);  // R12
  assign wr_psc  = wr_in && (addr_in == PSC_OFFSET);
  assign wr_arr  = wr_in && (addr_in == RELOAD_OFFSET);

  // ---------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      counter_enable        <= 1'b0;  // R17
      update_disable        <= 1'b0;
      update_request_source <= 1'b0;
      direction             <= 1'b0;
      center_align_select   <= CMS_EDGE;
      reload_preload_enable <= 1'b0;
    end else if (wr_ctrl) begin
      counter_enable        <= wdata_in[COUNTER_ENABLE_BIT];
      update_disable        <= wdata_in[UPDATE_DISABLE_BIT];
      update_request_source <= wdata_in[UPDATE_REQUEST_SOURCE_BIT];
      direction             <= wdata_in[DIRECTION_BIT];
      center_align_select   <= wdata_in[CENTER_ALIGN_LSB +: 2];
      reload_preload_enable <= wdata_in[RELOAD_PRELOAD_ENABLE_BIT];
    end
  end

  // Enable is delayed one cycle before the counter clock may run
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      counter_run <= 1'b0;
    end else begin
      counter_run <= counter_enable;  // R6
    end
  end

  // ---------------------------------------------------------------
  // Software update request
  // ---------------------------------------------------------------
  // Held for exactly one cycle, then dropped whether acted on or not
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      update_request <= 1'b0;
    end else if (wr_evt) begin
      update_request <= wdata_in[UPDATE_REQUEST_BIT];
    end else begin
      update_request <= 1'b0;  // R15
    end
  end

  assign sw_update    = update_request && !update_disable;  // R5 R10
  assign hw_update    = (overflow || underflow) && !update_disable;  // R5 R10
  assign update_event = sw_update || hw_update;
  // Request source set: only counter wrap raises the flag
  assign flag_set     = hw_update || (sw_update && !update_request_source);  // R8 R9

  // ---------------------------------------------------------------
  // Prescaler and its buffered division value
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      prescaler_register <= PSC_RESET;  // R17
    end else if (wr_psc) begin
      prescaler_register <= wdata_in[CNT_W-1:0];  // R12
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      prescaler_shadow <= PSC_RESET;
    end else if (update_event) begin
      prescaler_shadow <= prescaler_register;  // R3 R9
    end
  end

  ttbu_prescaler u_prescaler (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .enable_in  (counter_run),
    .clear_in   (sw_update),
    .div_in     (prescaler_shadow),
    .tick_out   (counter_clock)
  );

  // ---------------------------------------------------------------
  // Auto-reload preload and shadow
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      reload_register <= RELOAD_RESET;
    end else if (wr_arr) begin
      reload_register <= wdata_in[CNT_W-1:0];  // R12
    end
  end

  // A direct write wins over an update in the same cycle
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      reload_shadow <= RELOAD_RESET;
    end else if (wr_arr && !reload_preload_enable) begin
      reload_shadow <= wdata_in[CNT_W-1:0];  // R4
    end else if (update_event && reload_preload_enable) begin
      reload_shadow <= reload_register;  // R4 R9
    end
  end

  // ---------------------------------------------------------------
  // Counter
  // ---------------------------------------------------------------
  assign center_mode = (center_align_select != CMS_EDGE);  // R14
  assign count_down  = center_mode ? (center_dir == TTBU_DIR_DOWN) : direction;  // R16

  always_comb begin
    overflow   = 1'b0;
    underflow  = 1'b0;
    next_count = counter_register;
    if (counter_clock) begin
      if (center_mode) begin
        if (!count_down) begin
          next_count = counter_register + 16'h0001;
          overflow   = (next_count >= reload_shadow);  // R14
        end else if (counter_register <= 16'h0001) begin
          next_count = '0;
          underflow  = 1'b1;  // R14
        end else begin
          next_count = counter_register - 16'h0001;
        end
      end else if (count_down) begin
        if (counter_register == '0) begin
          next_count = reload_shadow;  // R13
          underflow  = 1'b1;
        end else begin
          next_count = counter_register - 16'h0001;
        end
      end else if (counter_register >= reload_shadow) begin
        next_count = '0;  // R7
        overflow   = 1'b1;
      end else begin
        next_count = counter_register + 16'h0001;  // R1
      end
    end
  end

  // Software write first, then forced update, then normal counting
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      counter_register <= COUNT_RESET;  // R17
    end else if (wr_cnt) begin
      counter_register <= wdata_in[CNT_W-1:0];  // R12
    end else if (sw_update) begin
      counter_register <= '0;  // R11
    end else begin
      counter_register <= next_count;
    end
  end

  // Hardware direction; overflow turns down, underflow or restart turns up
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      center_dir <= TTBU_DIR_UP;
    end else if (!center_mode || sw_update || underflow) begin
      center_dir <= TTBU_DIR_UP;  // R14
    end else if (overflow) begin
      center_dir <= TTBU_DIR_DOWN;
    end
  end

  // ---------------------------------------------------------------
  // Status, mask and interrupt
  // ---------------------------------------------------------------
  // A new event wins over a write-one clear in the same cycle
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      update_flag <= 1'b0;  // R17
    end else if (flag_set) begin
      update_flag <= 1'b1;  // R9
    end else if (wr_sts && wdata_in[UPDATE_FLAG_BIT]) begin
      update_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      update_mask <= 1'b0;
    end else if (wr_mask) begin
      update_mask <= wdata_in[UPDATE_FLAG_BIT];
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= update_flag && update_mask;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      update_event_out <= 1'b0;
    end else begin
      update_event_out <= update_event;
    end
  end

  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------
  // Unmapped addresses and idle cycles read as zero
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      rdata_out <= '0;
    end else begin
      rdata_out <= '0;
      if (rd_in) begin
        unique case (addr_in)
          CTRL_OFFSET: begin
            rdata_out[COUNTER_ENABLE_BIT]        <= counter_enable;
            rdata_out[UPDATE_DISABLE_BIT]        <= update_disable;
            rdata_out[UPDATE_REQUEST_SOURCE_BIT] <= update_request_source;
            rdata_out[DIRECTION_BIT]             <= count_down;
            rdata_out[CENTER_ALIGN_LSB +: 2]     <= center_align_select;
            rdata_out[RELOAD_PRELOAD_ENABLE_BIT] <= reload_preload_enable;
          end
          STATUS_OFFSET: rdata_out[UPDATE_FLAG_BIT] <= update_flag;
          MASK_OFFSET:   rdata_out[UPDATE_FLAG_BIT] <= update_mask;
          COUNT_OFFSET:  rdata_out[CNT_W-1:0] <= counter_register;  // R12
          PSC_OFFSET:    rdata_out[CNT_W-1:0] <= prescaler_register;
          RELOAD_OFFSET: rdata_out[CNT_W-1:0] <= reload_register;
          default:       rdata_out <= '0;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);

  enable_delay_a: assert property ($rose(counter_enable) |-> !counter_clock) // R6
    else $error("Counter clock ran in the cycle enable rose");
  no_clock_idle_a: assert property (!counter_run |-> !counter_clock) // R6
    else $error("Counter clock while disabled");
  request_clear_a: assert property (update_request && !wr_evt |=> !update_request) // R15
    else $error("Update request not cleared");
  update_block_a: assert property (update_disable |-> !update_event) // R10
    else $error("Update event while updates disabled");
  quiet_source_a: assert property (
    sw_update && update_request_source && !hw_update && !update_flag
      && !(wr_sts && !wdata_in[UPDATE_FLAG_BIT]) |=> !update_flag) // R8
    else $error("Flag raised by quiet software update");
  flag_raise_a: assert property (flag_set |=> update_flag) // R9
    else $error("Update flag not set by update");
  psc_load_a: assert property (update_event |=> prescaler_shadow == $past(prescaler_register)) // R3
    else $error("Prescaler shadow not loaded on update");
  psc_hold_a: assert property (!update_event |=> $stable(prescaler_shadow)) // R3
    else $error("Prescaler shadow changed outside update");
  reload_now_a: assert property (wr_arr && !reload_preload_enable
    |=> reload_shadow == $past(wdata_in[CNT_W-1:0])) // R4
    else $error("Reload shadow missed direct write");
  up_wrap_a: assert property (overflow && !center_mode && !wr_cnt && !sw_update
    |=> counter_register == 16'h0000) // R7
    else $error("Up count did not wrap to zero");
  down_wrap_a: assert property (underflow && !center_mode && !wr_cnt && !sw_update
    |=> counter_register == $past(reload_shadow)) // R13
    else $error("Down count did not restart from reload");
  sw_clear_a: assert property (sw_update && !wr_cnt |=> counter_register == 16'h0000) // R11
    else $error("Software update did not clear counter");
  irq_follow_a: assert property (update_flag && update_mask |=> irq_out)
    else $error("Interrupt missing for masked-in flag");

endmodule : ttbu_top
`default_nettype wire

// [include/ttbu_pkg.sv]
// Constants shared by the timer time-base unit
package ttbu_pkg;

  // ---------------------------------------------------------------
  // Register bus shape
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned CNT_W  = 16;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] CTRL_OFFSET   = 8'h00;
  localparam logic [7:0] EVTGEN_OFFSET = 8'h04;
  localparam logic [7:0] STATUS_OFFSET = 8'h08;
  localparam logic [7:0] MASK_OFFSET   = 8'h0c;
  localparam logic [7:0] COUNT_OFFSET  = 8'h10;
  localparam logic [7:0] PSC_OFFSET    = 8'h14;
  localparam logic [7:0] RELOAD_OFFSET = 8'h18;

  // ---------------------------------------------------------------
  // Control, event, status and mask field positions
  // ---------------------------------------------------------------
  localparam int unsigned COUNTER_ENABLE_BIT        = 0;
  localparam int unsigned UPDATE_DISABLE_BIT        = 1;
  localparam int unsigned UPDATE_REQUEST_SOURCE_BIT = 2;
  localparam int unsigned DIRECTION_BIT             = 4;
  localparam int unsigned CENTER_ALIGN_LSB          = 5;
  localparam int unsigned RELOAD_PRELOAD_ENABLE_BIT = 7;
  localparam int unsigned UPDATE_REQUEST_BIT        = 0;
  localparam int unsigned UPDATE_FLAG_BIT           = 0;

  // ---------------------------------------------------------------
  // Values after reset
  // ---------------------------------------------------------------
  localparam logic [15:0] COUNT_RESET  = 16'h0000;
  localparam logic [15:0] PSC_RESET    = 16'h0000;
  localparam logic [15:0] RELOAD_RESET = 16'hffff;
  localparam logic [1:0]  CMS_EDGE     = 2'h0;

  // Hardware count direction in centre-aligned mode
  typedef enum logic {
    TTBU_DIR_UP   = 1'b0,
    TTBU_DIR_DOWN = 1'b1
  } ttbu_dir_t;

endpackage : ttbu_pkg

// [hdl/ttbu_prescaler.sv]
// Prescaler counter of the timer time-base unit
`timescale 1ns/10ps
`default_nettype none
module ttbu_prescaler (
  // Clock and reset
  input  wire logic                      clk_sys_in,
  input  wire logic                      rst_n_in,
  // Control
  input  wire logic                      enable_in,
  input  wire logic                      clear_in,
  input  wire logic [ttbu_pkg::CNT_W-1:0] div_in,
  // Counter clock tick
  output logic                           tick_out
);
  import ttbu_pkg::*;

  logic [CNT_W-1:0] count;

  // Division factor is div_in + 1, so 0 gives a tick every cycle
  assign tick_out = enable_in && !clear_in && (count == div_in);  // R2

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      count <= PSC_RESET;  // R17
    end else if (clear_in) begin
      count <= '0;  // R11
    end else if (enable_in) begin
      count <= tick_out ? '0 : count + 16'h0001;
    end
  end

endmodule : ttbu_prescaler
`default_nettype wire

// [test/tb.sv]
// Self-checking testbench of the timer time-base unit
`timescale 1ns/10ps
`default_nettype none
module tb;
  import ttbu_pkg::*;

  // ---------------------------------------------------------------
  // Control word pieces
  // ---------------------------------------------------------------
  localparam logic [31:0] EN   = 32'h1 << COUNTER_ENABLE_BIT;
  localparam logic [31:0] UDIS = 32'h1 << UPDATE_DISABLE_BIT;
  localparam logic [31:0] URS  = 32'h1 << UPDATE_REQUEST_SOURCE_BIT;
  localparam logic [31:0] DIR  = 32'h1 << DIRECTION_BIT;
  localparam logic [31:0] PRE  = 32'h1 << RELOAD_PRELOAD_ENABLE_BIT;
  localparam logic [7:0]  UNMAPPED = 8'h20;

  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic              clk_sys_in;
  logic              rst_n_in;
  logic [ADDR_W-1:0] addr_in;
  logic [DATA_W-1:0] wdata_in;
  logic              wr_in;
  logic              rd_in;
  logic [DATA_W-1:0] rdata_out;
  logic              update_event_out;
  logic              irq_out;
  logic [DATA_W-1:0] v;
  int                bad_count = 0;
  int                n_compared = 0;
  int                ev_cnt = 0;
  int                ev0;
  logic [7:0]        offs [8];
  logic [31:0]       rst_v [8];

  ttbu_top dut (
    .clk_sys_in       (clk_sys_in),
    .rst_n_in         (rst_n_in),
    .addr_in          (addr_in),
    .wdata_in         (wdata_in),
    .wr_in            (wr_in),
    .rd_in            (rd_in),
    .rdata_out        (rdata_out),
    .update_event_out (update_event_out),
    .irq_out          (irq_out)
  );

  initial begin
    clk_sys_in = 1'b0;
    forever #2 clk_sys_in = ~clk_sys_in;
  end

  // Pulses are one cycle wide, so one increment per edge is exact
  always @(posedge clk_sys_in) begin
    if (update_event_out === 1'b1) ev_cnt <= ev_cnt + 1;
  end

  // ---------------------------------------------------------------
  // Bus and compare tasks
  // ---------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge clk_sys_in);
    wr_in <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge clk_sys_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask : rd

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("[FAIL] %0t value got %h expected %h", $time, got, exp);
      bad_count++;
    end
  endtask : chk_reg

  task automatic chk_num(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("[FAIL] %0t count got %0d expected %0d", $time, got, exp);
      bad_count++;
    end
  endtask : chk_num

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    chk_reg(d, exp);
  endtask : rdchk

  // Update pulses seen over n edges
  task automatic window(input int n, input int exp);
    int s;
    s = ev_cnt;
    repeat (n) @(posedge clk_sys_in);
    chk_num(ev_cnt - s, exp);
  endtask : window

  // Counter steps between two reads twelve edges apart
  task automatic rate(input bit down, input int exp);
    logic [31:0] a;
    logic [31:0] b;
    logic [15:0] d;
    rd(COUNT_OFFSET, a);
    repeat (10) @(posedge clk_sys_in);
    rd(COUNT_OFFSET, b);
    d = down ? (a[15:0] - b[15:0]) : (b[15:0] - a[15:0]);
    chk_num({16'h0, d}, exp);
  endtask : rate

  task automatic soft_update(input int exp);
    ev0 = ev_cnt;
    wr(EVTGEN_OFFSET, 32'h1);
    repeat (3) @(posedge clk_sys_in);
    chk_num(ev_cnt - ev0, exp);
  endtask : soft_update

  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results

  // ---------------------------------------------------------------
  // Watchdog: the sequence needs under a thousand cycles
  // ---------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    bad_count++;
    results();
  end

  // ---------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------
  initial begin
    rst_n_in = 1'b0;
    addr_in  = '0;
    wdata_in = '0;
    wr_in    = 1'b0;
    rd_in    = 1'b0;
    offs  = '{CTRL_OFFSET, EVTGEN_OFFSET, STATUS_OFFSET, MASK_OFFSET,
              COUNT_OFFSET, PSC_OFFSET, RELOAD_OFFSET, UNMAPPED};
    rst_v = '{32'h0, 32'h0, 32'h0, 32'h0, {16'h0, COUNT_RESET},
              {16'h0, PSC_RESET}, {16'h0, RELOAD_RESET}, 32'h0};
    repeat (8) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    foreach (offs[i]) rdchk(offs[i], rst_v[i]);
    chk_reg({31'h0, irq_out}, 32'h0);
    // Stopped counter holds a written value; unmapped writes vanish
    wr(COUNT_OFFSET, 32'h1234);
    rdchk(COUNT_OFFSET, 32'h1234);
    rate(1'b0, 0);
    wr(UNMAPPED, 32'hffffffff);
    rdchk(UNMAPPED, 32'h0);
    // Up counting, reload without preload taken at once
    wr(COUNT_OFFSET, 32'h0);
    wr(CTRL_OFFSET, EN);
    repeat (4) @(posedge clk_sys_in);
    rate(1'b0, 12);
    wr(RELOAD_OFFSET, 32'h3);
    wr(COUNT_OFFSET, 32'h0);
    rdchk(RELOAD_OFFSET, 32'h3);
    // Read data stand one cycle only, then drop to zero
    @(posedge clk_sys_in);
    #1 chk_reg(rdata_out, 32'h0);
    repeat (8) @(posedge clk_sys_in);
    window(48, 12);
    rdchk(STATUS_OFFSET, 32'h1);
    chk_reg({31'h0, irq_out}, 32'h0);
    wr(MASK_OFFSET, 32'h1);
    repeat (2) @(posedge clk_sys_in);
    chk_reg({31'h0, irq_out}, 32'h1);
    // Down counting
    wr(CTRL_OFFSET, EN | DIR);
    repeat (8) @(posedge clk_sys_in);
    window(48, 12);
    wr(RELOAD_OFFSET, 32'h100);
    repeat (8) @(posedge clk_sys_in);
    rate(1'b1, 12);
    // Centre modes ignore the direction bit: two updates per six steps
    wr(RELOAD_OFFSET, 32'h3);
    wr(COUNT_OFFSET, 32'h0);
    for (int cms = 1; cms < 4; cms++) begin
      wr(CTRL_OFFSET, EN | DIR | (32'(cms) << CENTER_ALIGN_LSB));
      repeat (8) @(posedge clk_sys_in);
      window(48, 16);
    end
    // Prescaler buffered until an update
    wr(CTRL_OFFSET, EN);
    wr(RELOAD_OFFSET, 32'hfff);
    wr(COUNT_OFFSET, 32'h0);
    wr(PSC_OFFSET, 32'h2);
    rdchk(PSC_OFFSET, 32'h2);
    rate(1'b0, 12);
    wr(EVTGEN_OFFSET, 32'h1);
    rd(COUNT_OFFSET, v);
    chk_num(int'(v[15:0] < 16'h3), 1);
    rdchk(EVTGEN_OFFSET, 32'h0);
    rate(1'b0, 4);
    rdchk(PSC_OFFSET, 32'h2);
    // Update disable blocks software updates and the prescaler load
    wr(CTRL_OFFSET, EN | UDIS);
    wr(PSC_OFFSET, 32'h0);
    soft_update(0);
    rate(1'b0, 4);
    // Flag clear, then request source suppresses the flag
    wr(CTRL_OFFSET, 32'h0);
    wr(STATUS_OFFSET, 32'h1);
    repeat (2) @(posedge clk_sys_in);
    rdchk(STATUS_OFFSET, 32'h0);
    chk_reg({31'h0, irq_out}, 32'h0);
    wr(CTRL_OFFSET, URS);
    soft_update(1);
    rdchk(STATUS_OFFSET, 32'h0);
    chk_reg({31'h0, irq_out}, 32'h0);
    wr(CTRL_OFFSET, 32'h0);
    soft_update(1);
    rdchk(STATUS_OFFSET, 32'h1);
    chk_reg({31'h0, irq_out}, 32'h1);
    // Preload: new reload waits for an update
    wr(RELOAD_OFFSET, 32'h3);
    wr(COUNT_OFFSET, 32'h0);
    wr(CTRL_OFFSET, EN | UDIS | PRE);
    wr(RELOAD_OFFSET, 32'h7);
    repeat (6) begin
      rd(COUNT_OFFSET, v);
      chk_num(int'(v[15:0] <= 16'h3), 1);
    end
    wr(CTRL_OFFSET, EN | PRE);
    repeat (16) @(posedge clk_sys_in);
    window(48, 6);
    results();
  end

endmodule : tb
`default_nettype wire
